//--- src/anpm_map.vh
// constants of the negotiation progress monitor block
// assumes a 100 MHz clock and register indices scaled by four for bytes
//
// Functional notes
// - no reply to bursts: run parallel detection, clear partner capable bit
// - parallel detection sets partner bit 5 (10M half) or 7 (100M half)
// - detection done: set complete bit, enable found technology, disable others
// - normal link pulses in reply mean a 10M-only partner without negotiation
// - scrambled 100M idles in reply mean a 100M partner without negotiation
// - bursts in reply set the partner capable bit in expansion register
// - no receive signal sets the consolidated no-signal bit
// - several indications at once: enable nothing, set detection fault bit
// - partner fault sets every remote fault status bit
// - local link fault sends remote fault and sets advertised fault bit
// - with negotiation enabled, start after power-up and on request
// - any reset idles arbiter and monitor and clears progress bits
// - restart reinitialises the arbiter only, monitor and its progress bits kept
// - after completion only a status read or reset changes progress bits
// - link failure or self-clearing restart bit restarts negotiation
// - enable bit toggled one-zero-one restarts negotiation
// - consolidated register shows rate, duplex, link and remote fault copies
// - progress code: complete bit then three progress bits, 0h-8h or Fh
// - between reads, monitor latches arbiter state only when it exceeds held value
// - read returns held code, then latches present state unconditionally
// - after completion first read shows 1/111, later reads 1/000
// - mode priority: 100 full, T4, 100 half, 10 full, 10 half; code never selects T4
// - sent word comes from advertisement, received word stored as partner
`ifndef ANPM_MAP_VH
`define ANPM_MAP_VH

// ==========================================
// register indices, byte address is four times these
`define ANPM_IDX_CTRL 6'd0
`define ANPM_IDX_STAT 6'd1
`define ANPM_IDX_ADV 6'd4
`define ANPM_IDX_LPA 6'd5
`define ANPM_IDX_EXP 6'd6
`define ANPM_IDX_CSR 6'd17
`define ANPM_IDX_MODE 6'd19

// ==========================================
// field positions
`define ANPM_CTRL_SRST 15
`define ANPM_CTRL_ANEN 12
`define ANPM_CTRL_RSTRT 9
`define ANPM_STAT_CMPL 5
`define ANPM_STAT_RF 4
`define ANPM_STAT_ABLE 3
`define ANPM_STAT_LINK 2
`define ANPM_ABIL_RF 13
`define ANPM_ABIL_T4 9
`define ANPM_ABIL_TXFD 8
`define ANPM_ABIL_TXHD 7
`define ANPM_ABIL_10FD 6
`define ANPM_ABIL_10HD 5
`define ANPM_EXP_PDF 4
`define ANPM_EXP_LPAN 0
`define ANPM_CSR_RATE 15
`define ANPM_CSR_DPLX 14
`define ANPM_CSR_CMPL 4
`define ANPM_CSR_NOSIG 3
`define ANPM_CSR_RF 1
`define ANPM_CSR_LINK 0
`define ANPM_MODE_RF 13

// ==========================================
// reset values and timing
`define ANPM_ADV_RST 16'h01e1
`define ANPM_ANEN_RST 1'b1
`define ANPM_CLK_MHZ 16'd100
`define ANPM_TIMER_US 16'd50

`endif

//--- src/anpm_sync.v
// three-stage level synchroniser for pins from the analog side
// assumes inputs change slowly compared with the clock
`timescale 1ns/10ps
module anpm_sync #(
  parameter W = 3
) (
  // clock and reset
  input wire aclk,
  input wire aresetn,
  // levels
  input wire [W-1:0] d,
  output reg [W-1:0] q
);
  reg [W-1:0] s1;
  reg [W-1:0] s2;
  reg [W-1:0] s3;
  integer i;

  // ==========================================
  // output follows only once stages two and three agree
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s1 <= {W{1'b0}};
      s2 <= {W{1'b0}};
      s3 <= {W{1'b0}};
      q <= {W{1'b0}};
    end
    else
    begin
      s1 <= d;
      s2 <= s1;
      s3 <= s2;
      for (i = 0; i < W; i = i + 1)
        if (s2[i] == s3[i])
          q[i] <= s3[i];
    end
  end
endmodule // anpm_sync

//--- src/anpm_prog_mon.v
// progress monitor: holds the highest arbitration state seen since the last read
// assumes read_done is a one-cycle pulse after the held code was returned
`timescale 1ns/10ps
module anpm_prog_mon (
  // clock and reset
  input wire aclk,
  input wire aresetn,
  input wire sreset,
  // arbiter side
  input wire [3:0] state_code,
  // management side
  input wire read_done,
  output reg [3:0] code
);
  // ==========================================
  // a restart is deliberately not an input: held bits survive it
  always @(posedge aclk)
  begin
    if (!aresetn || sreset)
      code <= 4'h0;
    else if (read_done)
      code <= state_code;
    else if (state_code > code)
      code <= state_code;
  end
endmodule // anpm_prog_mon

//--- src/anpm_top.v
// negotiation arbiter, parallel detection and status registers
// assumes receive detectors on this clock and analog pins that are async
`timescale 1ns/10ps
`include "anpm_map.vh"
module anpm_top #(
  parameter [15:0] TIMER_CYC = `ANPM_TIMER_US * `ANPM_CLK_MHZ
) (
  // clock and reset
  input wire aclk,
  input wire aresetn,
  // axi4-lite write address
  input wire [7:0] awaddr,
  input wire awvalid,
  output reg awready,
  // axi4-lite write data
  input wire [31:0] wdata,
  input wire [3:0] wstrb,
  input wire wvalid,
  output reg wready,
  // axi4-lite write response
  output reg [1:0] bresp,
  output reg bvalid,
  input wire bready,
  // axi4-lite read address
  input wire [7:0] araddr,
  input wire arvalid,
  output reg arready,
  // axi4-lite read data
  output reg [31:0] rdata,
  output reg [1:0] rresp,
  output reg rvalid,
  input wire rready,
  // receive detectors, same clock
  input wire rx_flp,
  input wire rx_nlp,
  input wire rx_idle100,
  input wire [15:0] rx_word,
  input wire rx_word_valid,
  // analog pins
  input wire rx_energy,
  input wire local_fault,
  input wire link_ok,
  // transmit and technology control
  output reg tx_flp_en,
  output reg [15:0] tx_word,
  output reg en_100tx,
  output reg en_10t,
  output reg full_duplex
);
  localparam [3:0] ST_IDLE = 4'h0;
  localparam [3:0] ST_XDIS = 4'h1;
  localparam [3:0] ST_ABIL = 4'h2;
  localparam [3:0] ST_ACK = 4'h3;
  localparam [3:0] ST_CACK = 4'h4;
  localparam [3:0] ST_PDCHK = 4'h5;
  localparam [3:0] ST_LGCHK = 4'h6;
  localparam [3:0] ST_PDF = 4'h7;
  localparam [3:0] ST_UP = 4'h8;
  localparam [3:0] ST_DONE = 4'hf;

  // ==========================================
  // functions
  function reg_hit;
    input [5:0] idx;
    begin
      reg_hit = (idx == `ANPM_IDX_CTRL) || (idx == `ANPM_IDX_STAT) ||
                (idx == `ANPM_IDX_ADV) || (idx == `ANPM_IDX_LPA) ||
                (idx == `ANPM_IDX_EXP) || (idx == `ANPM_IDX_CSR) ||
                (idx == `ANPM_IDX_MODE);
    end
  endfunction

  // returns {valid, 100M, full}; T4 ranks second but is never selected
  function [2:0] resolve;
    input [15:0] c;
    begin
      if (c[`ANPM_ABIL_TXFD])
        resolve = 3'b111;
      else if (c[`ANPM_ABIL_TXHD])
        resolve = 3'b110;
      else if (c[`ANPM_ABIL_10FD])
        resolve = 3'b101;
      else if (c[`ANPM_ABIL_10HD])
        resolve = 3'b100;
      else
        resolve = 3'b000;
    end
  endfunction

  function [15:0] merge;
    input [15:0] old;
    input [31:0] d;
    input [3:0] be;
    begin
      merge = old;
      if (be[0])
        merge[7:0] = d[7:0];
      if (be[1])
        merge[15:8] = d[15:8];
    end
  endfunction

  // ==========================================
  // synchronised pins
  wire energy_s;
  wire lfault_s;
  wire link_s;

  anpm_sync #(.W(3)) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .d({rx_energy, local_fault, link_ok}),
    .q({energy_s, lfault_s, link_s})
  );

  // ==========================================
  // state
  reg [3:0] state;
  reg [15:0] tmr;
  reg an_en;
  reg an_en_d;
  reg rstrt;
  reg sreset;
  reg [15:0] adv;
  reg [15:0] lpa;
  reg partner_negotiation_capable;
  reg pd_fault;
  reg an_cmpl;
  reg link_up;
  reg no_sig;
  reg aw_held;
  reg w_held;
  reg [5:0] aw_idx;
  reg [31:0] w_data;
  reg [3:0] w_strb;
  reg [5:0] rd_idx;
  reg [31:0] rd_word;
  wire [3:0] prog;

  wire wr_go = aw_held && w_held && !bvalid;
  wire rd_done = rvalid && rready;
  wire csr_read = rd_done && (rd_idx == `ANPM_IDX_CSR);
  wire exp_read = rd_done && (rd_idx == `ANPM_IDX_EXP);
  wire multi = (rx_flp & rx_nlp) | (rx_flp & rx_idle100) | (rx_nlp & rx_idle100);
  wire tmr_done = (tmr == 16'h0000);
  wire restart = rstrt || (an_en && !an_en_d) ||
                 (state == ST_UP && !link_s);
  wire [2:0] tech = resolve(adv & lpa);
  wire hw_rst = !aresetn || sreset;

  anpm_prog_mon u_mon (
    .aclk(aclk),
    .aresetn(aresetn),
    .sreset(sreset),
    .state_code(state),
    .read_done(csr_read),
    .code(prog)
  );

  // ==========================================
  // axi4-lite slave
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      awready <= 1'b1;
      wready <= 1'b1;
      bvalid <= 1'b0;
      bresp <= 2'b00;
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_idx <= 6'h00;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= 32'h00000000;
      rresp <= 2'b00;
      rd_idx <= 6'h00;
    end
    else
    begin
      if (awvalid && awready)
      begin
        awready <= 1'b0;
        aw_held <= 1'b1;
        aw_idx <= awaddr[7:2];
      end
      if (wvalid && wready)
      begin
        wready <= 1'b0;
        w_held <= 1'b1;
        w_data <= wdata;
        w_strb <= wstrb;
      end
      if (wr_go)
      begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        bvalid <= 1'b1;
        bresp <= reg_hit(aw_idx) ? 2'b00 : 2'b10;
      end
      if (bvalid && bready)
      begin
        bvalid <= 1'b0;
        awready <= 1'b1;
        wready <= 1'b1;
      end
      if (arvalid && arready)
      begin
        arready <= 1'b0;
        rvalid <= 1'b1;
        rdata <= rd_word;
        rresp <= reg_hit(araddr[7:2]) ? 2'b00 : 2'b10;
        rd_idx <= araddr[7:2];
      end
      if (rd_done)
      begin
        rvalid <= 1'b0;
        arready <= 1'b1;
      end
    end
  end

  // ==========================================
  // read mux
  always @*
  begin
    rd_word = 32'h00000000;
    case (araddr[7:2])
      `ANPM_IDX_CTRL:
      begin
        rd_word[`ANPM_CTRL_ANEN] = an_en;
        rd_word[`ANPM_CTRL_RSTRT] = rstrt;
      end
      `ANPM_IDX_STAT:
      begin
        rd_word[`ANPM_STAT_CMPL] = an_cmpl;
        rd_word[`ANPM_STAT_RF] = lpa[`ANPM_ABIL_RF];
        rd_word[`ANPM_STAT_ABLE] = 1'b1;
        rd_word[`ANPM_STAT_LINK] = link_up;
      end
      `ANPM_IDX_ADV:
        rd_word[15:0] = adv;
      `ANPM_IDX_LPA:
        rd_word[15:0] = lpa;
      `ANPM_IDX_EXP:
      begin
        rd_word[`ANPM_EXP_PDF] = pd_fault;
        rd_word[`ANPM_EXP_LPAN] = partner_negotiation_capable;
      end
      `ANPM_IDX_CSR:
      begin
        rd_word[`ANPM_CSR_RATE] = en_100tx;
        rd_word[`ANPM_CSR_DPLX] = full_duplex;
        rd_word[13:11] = prog[2:0];
        rd_word[`ANPM_CSR_CMPL] = prog[3];
        rd_word[`ANPM_CSR_NOSIG] = no_sig;
        rd_word[`ANPM_CSR_RF] = lpa[`ANPM_ABIL_RF];
        rd_word[`ANPM_CSR_LINK] = link_up;
      end
      `ANPM_IDX_MODE:
        rd_word[`ANPM_MODE_RF] = lpa[`ANPM_ABIL_RF];
      default:
        rd_word = 32'h00000000;
    endcase
  end

  // ==========================================
  // software registers
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      an_en <= `ANPM_ANEN_RST;
      an_en_d <= `ANPM_ANEN_RST;
      rstrt <= 1'b0;
      sreset <= 1'b0;
      adv <= `ANPM_ADV_RST;
    end
    else
    begin
      an_en_d <= an_en;
      rstrt <= 1'b0; // self-clearing, visible one cycle at most
      sreset <= 1'b0;
      if (wr_go && aw_idx == `ANPM_IDX_CTRL)
      begin
        if (w_strb[1])
        begin
          an_en <= w_data[`ANPM_CTRL_ANEN];
          rstrt <= w_data[`ANPM_CTRL_RSTRT];
          sreset <= w_data[`ANPM_CTRL_SRST];
        end
      end
      if (wr_go && aw_idx == `ANPM_IDX_ADV)
        adv <= merge(adv, w_data, w_strb);
      // hardware set wins over a software write
      if (lfault_s)
        adv[`ANPM_ABIL_RF] <= 1'b1;
    end
  end

  // ==========================================
  // arbitration machine and detection results
  always @(posedge aclk)
  begin
    if (hw_rst)
    begin
      state <= ST_IDLE;
      tmr <= TIMER_CYC;
      lpa <= 16'h0000;
      partner_negotiation_capable <= 1'b0;
      pd_fault <= 1'b0;
      an_cmpl <= 1'b0;
      en_100tx <= 1'b0;
      en_10t <= 1'b0;
      full_duplex <= 1'b0;
      tx_flp_en <= 1'b0;
      tx_word <= 16'h0000;
      link_up <= 1'b0;
      no_sig <= 1'b0;
    end
    else
    begin
      no_sig <= !energy_s;
      link_up <= link_s && (state == ST_UP);
      tx_word <= adv;
      tx_flp_en <= (state == ST_ABIL) || (state == ST_ACK) || (state == ST_CACK);
      if (!tmr_done)
        tmr <= tmr - 16'd1;
      // pd fault flag: a new fault wins over the clearing read
      if (exp_read)
        pd_fault <= 1'b0;
      if (!an_en)
      begin
        state <= ST_IDLE;
        an_cmpl <= 1'b0;
        en_100tx <= 1'b0;
        en_10t <= 1'b0;
        full_duplex <= 1'b0;
      end
      else if (restart)
      begin
        state <= ST_XDIS;
        tmr <= TIMER_CYC;
        an_cmpl <= 1'b0;
        en_100tx <= 1'b0;
        en_10t <= 1'b0;
        // duplex follows the enables, never left over from the last link
        full_duplex <= 1'b0;
      end
      else
      begin
        case (state)
          ST_IDLE:
          begin
            state <= ST_XDIS;
            tmr <= TIMER_CYC;
          end
          ST_XDIS:
            if (tmr_done)
            begin
              state <= ST_ABIL;
              tmr <= TIMER_CYC;
            end
          ST_ABIL:
            if (multi)
            begin
              state <= ST_PDF;
              pd_fault <= 1'b1;
              en_100tx <= 1'b0;
              en_10t <= 1'b0;
            end
            else if (rx_flp)
            begin
              state <= ST_ACK;
              partner_negotiation_capable <= 1'b1;
            end
            else if (rx_nlp)
            begin
              state <= ST_PDCHK;
              tmr <= TIMER_CYC;
              partner_negotiation_capable <= 1'b0;
              lpa <= 16'h0000 | (16'h0001 << `ANPM_ABIL_10HD);
            end
            else if (rx_idle100)
            begin
              state <= ST_PDCHK;
              tmr <= TIMER_CYC;
              partner_negotiation_capable <= 1'b0;
              lpa <= 16'h0000 | (16'h0001 << `ANPM_ABIL_TXHD);
            end
          ST_ACK:
            if (rx_word_valid)
            begin
              lpa <= rx_word;
              state <= ST_CACK;
              tmr <= TIMER_CYC;
            end
          ST_CACK:
            if (tmr_done)
            begin
              state <= ST_LGCHK;
              tmr <= TIMER_CYC;
            end
          ST_PDCHK, ST_LGCHK:
            if (!tech[2])
              state <= ST_XDIS;
            else if (link_s)
              state <= ST_DONE;
            else if (tmr_done)
            begin
              state <= ST_XDIS;
              tmr <= TIMER_CYC;
            end
          ST_PDF:
            if (tmr_done)
            begin
              state <= ST_ABIL;
              tmr <= TIMER_CYC;
            end
          ST_DONE:
          begin
            state <= ST_UP;
            an_cmpl <= 1'b1;
            en_100tx <= tech[1];
            en_10t <= !tech[1];
            full_duplex <= tech[0];
          end
          ST_UP:
            state <= ST_UP; // link failure handled as a restart
          default:
            state <= ST_IDLE;
        endcase
      end
    end
  end
endmodule // anpm_top

//--- verification/anpm_checker_assertions.sv
// bus and technology output checks for the negotiation block
// assumes it sees only the top module ports, one clock domain
`timescale 1ns/10ps
module anpm_checker #(
  parameter [15:0] TIMER_CYC = 16'd8
) (
  // clock and reset
  input wire aclk,
  input wire aresetn,
  // register bus
  input wire awvalid,
  input wire awready,
  input wire wvalid,
  input wire wready,
  input wire [1:0] bresp,
  input wire bvalid,
  input wire bready,
  input wire arvalid,
  input wire arready,
  input wire [31:0] rdata,
  input wire [1:0] rresp,
  input wire rvalid,
  input wire rready,
  // technology control
  input wire en_100tx,
  input wire en_10t,
  input wire full_duplex
);
  // ========
  // assertions
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  write_answer_a: assert property (awvalid && awready && wvalid && wready |-> ##[1:2] bvalid)
    else $error("write response late");
  read_answer_a: assert property (arvalid && arready |-> ##[1:2] rvalid)
    else $error("read data late");
  bresp_hold_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped early");
  rdata_hold_a: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data dropped early");
  read_done_a: assert property (rvalid && rready |=> !rvalid && arready)
    else $error("read not closed");
  read_block_a: assert property (rvalid |-> !arready)
    else $error("read accepted while busy");
  upper_zero_a: assert property (rvalid |-> rdata[31:16] == 16'h0000 && rresp != 2'b01)
    else $error("upper read bits set");
  slverr_zero_a: assert property (rvalid && rresp == 2'b10 |-> rdata == 32'h0)
    else $error("error read carries data");
  tech_single_a: assert property (!(en_100tx && en_10t))
    else $error("two technologies enabled");
  duplex_tech_a: assert property (full_duplex |-> en_100tx || en_10t)
    else $error("duplex without technology");
  cover property (bvalid && bresp == 2'b10);
  cover property ($rose(en_100tx));
  cover property ($rose(en_10t));
endmodule // anpm_checker

bind anpm_top anpm_checker #(.TIMER_CYC(TIMER_CYC)) u_chk (
  .aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready), .wvalid(wvalid),
  .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .arvalid(arvalid),
  .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
  .en_100tx(en_100tx), .en_10t(en_10t), .full_duplex(full_duplex)
);

//--- verification/anpm_partner.sv
// remote link partner: 0 silent, 1 bursts, 2 link pulses, 3 idles, 4 mixed
// assumes the same clock as the device detectors
`timescale 1ns/10ps
module anpm_partner (
  // control
  input wire aclk,
  input wire [2:0] mode,
  input wire [15:0] word,
  // line indications
  output reg rx_flp = 1'b0,
  output reg rx_nlp = 1'b0,
  output reg rx_idle100 = 1'b0,
  output reg [15:0] rx_word = 16'h0000,
  output reg rx_word_valid = 1'b0,
  output reg rx_energy = 1'b0,
  output reg link_ok = 1'b0
);
  reg [3:0] cnt = 4'h0;
  // a code word every 16 cycles, so the ack state always sees one
  always @(posedge aclk)
  begin
    cnt <= cnt + 4'h1;
    rx_flp <= (mode == 3'd1);
    rx_nlp <= (mode == 3'd2) || (mode == 3'd4);
    rx_idle100 <= (mode == 3'd3) || (mode == 3'd4);
    rx_energy <= (mode != 3'd0);
    link_ok <= (mode != 3'd0) && (mode != 3'd4);
    rx_word_valid <= (mode == 3'd1) && (cnt == 4'h0);
    // word lines toggle between words so a stale value never looks valid
    rx_word <= ((mode == 3'd1) && (cnt == 4'h0)) ? word : ~rx_word;
  end
endmodule // anpm_partner

//--- verification/autoneg_parallel_detect_monitor_bench.sv
// register-level tests of negotiation, detection and progress codes
// assumes the partner model on the detector pins, timer shortened to 8
`timescale 1ns/10ps
`include "anpm_map.vh"
module autoneg_parallel_detect_monitor_bench;
  reg aclk;
  reg aresetn = 1'b0;
  reg [7:0] awaddr = 8'h00;
  reg awvalid = 1'b0;
  reg [31:0] wdata = 32'h0;
  reg [3:0] wstrb = 4'hf;
  reg wvalid = 1'b0;
  reg bready = 1'b0;
  reg [7:0] araddr = 8'h00;
  reg arvalid = 1'b0;
  reg rready = 1'b0;
  reg local_fault = 1'b0;
  reg [2:0] mode = 3'd1;
  reg [15:0] word = 16'h21e1;
  wire awready, wready, bvalid, arready, rvalid, rx_flp, rx_nlp, rx_idle100, rx_word_valid;
  wire rx_energy, link_ok, tx_flp_en, en_100tx, en_10t, full_duplex;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  wire [15:0] rx_word, tx_word;
  integer mismatches = 0;
  integer check_count = 0;
  integer cycles = 0;
  reg [31:0] rv;
  reg go;
  anpm_top #(.TIMER_CYC(16'd8)) u_dut (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .rx_flp(rx_flp), .rx_nlp(rx_nlp), .rx_idle100(rx_idle100), .rx_word(rx_word),
    .rx_word_valid(rx_word_valid), .rx_energy(rx_energy), .local_fault(local_fault),
    .link_ok(link_ok), .tx_flp_en(tx_flp_en), .tx_word(tx_word), .en_100tx(en_100tx),
    .en_10t(en_10t), .full_duplex(full_duplex)
  );
  anpm_partner u_partner (
    .aclk(aclk), .mode(mode), .word(word), .rx_flp(rx_flp), .rx_nlp(rx_nlp),
    .rx_idle100(rx_idle100), .rx_word(rx_word), .rx_word_valid(rx_word_valid),
    .rx_energy(rx_energy), .link_ok(link_ok)
  );
  // ========
  // clock, timeout and verdict
  initial
  begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  task test_done;
    begin
      if (mismatches == 0 && check_count > 0)
        $display("RESULT: PASS");
      else
        $display("RESULT: FAIL");
      $finish;
    end
  endtask
  always @(posedge aclk)
  begin
    cycles <= cycles + 1;
    if (cycles == 60000)
    begin
      mismatches = mismatches + 1;
      test_done;
    end
  end
  // ========
  // bus tasks
  task chk(input [15:0] got, input [15:0] exp);
    begin
      check_count = check_count + 1;
      if (got !== exp)
      begin
        mismatches = mismatches + 1;
        $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task wr(input [5:0] i, input [15:0] d, input [1:0] er);
    begin
      @(posedge aclk);
      awaddr <= {i, 2'b00};
      wdata <= {16'h0000, d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      go = 1'b1;
      while (go)
      begin
        @(posedge aclk);
        if (awready === 1'b1)
          awvalid <= 1'b0;
        if (wready === 1'b1)
          wvalid <= 1'b0;
        if (bvalid === 1'b1)
        begin
          go = 1'b0;
          bready <= 1'b0;
          chk({14'h0, bresp}, {14'h0, er});
        end
      end
    end
  endtask
  task rd(input [5:0] i, input [1:0] er);
    begin
      @(posedge aclk);
      araddr <= {i, 2'b00};
      arvalid <= 1'b1;
      rready <= 1'b1;
      go = 1'b1;
      while (go)
      begin
        @(posedge aclk);
        if (arready === 1'b1)
          arvalid <= 1'b0;
        if (rvalid === 1'b1)
        begin
          go = 1'b0;
          rv = rdata;
          rready <= 1'b0;
          chk({14'h0, rresp}, {14'h0, er});
        end
      end
    end
  endtask
  // a read of index 6 clears the detection fault, but a lasting fault sets it again
  task poll(input [5:0] i, input [3:0] b, input v);
    integer n;
    begin
      n = 0;
      rd(i, 2'b00);
      while (rv[b] !== v && n < 300)
      begin
        rd(i, 2'b00);
        n = n + 1;
      end
      chk({15'h0, rv[b]}, {15'h0, v});
    end
  endtask
  // ========
  // tests
  initial
  begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    rd(`ANPM_IDX_ADV, 2'b00);
    chk(rv[15:0], `ANPM_ADV_RST);
    chk(tx_word, `ANPM_ADV_RST);
    rd(6'd2, 2'b10);
    chk(rv[15:0], 16'h0000);
    wr(6'd3, 16'hffff, 2'b10);
    poll(`ANPM_IDX_STAT, 5, 1'b1);
    rd(`ANPM_IDX_LPA, 2'b00);
    chk(rv[15:0], 16'h21e1);
    rd(`ANPM_IDX_EXP, 2'b00);
    chk({15'h0, rv[0]}, 16'h0001);
    rd(`ANPM_IDX_STAT, 2'b00);
    chk({15'h0, rv[4]}, 16'h0001);
    rd(`ANPM_IDX_MODE, 2'b00);
    chk({15'h0, rv[13]}, 16'h0001);
    chk({13'h0, en_100tx, en_10t, full_duplex}, 16'h0005);
    rd(`ANPM_IDX_CSR, 2'b00);
    chk({8'h0, rv[15:14], rv[4], rv[13:11], rv[1:0]}, 16'h00ff);
    rd(`ANPM_IDX_CSR, 2'b00);
    chk({12'h0, rv[4], rv[13:11]}, 16'h0008);
    wr(`ANPM_IDX_CTRL, 16'h1200, 2'b00);
    rd(`ANPM_IDX_CSR, 2'b00);
    chk({12'h0, rv[4], rv[13:11]}, 16'h0008);
    rd(`ANPM_IDX_CTRL, 2'b00);
    chk({15'h0, rv[9]}, 16'h0000);
    chk({13'h0, en_100tx, en_10t, full_duplex}, 16'h0000);
    poll(`ANPM_IDX_STAT, 5, 1'b0);
    poll(`ANPM_IDX_STAT, 5, 1'b1);
    rd(`ANPM_IDX_CSR, 2'b00);
    chk({12'h0, rv[4], rv[13:11]}, 16'h000f);
    local_fault <= 1'b1;
    repeat (8) @(posedge aclk);
    rd(`ANPM_IDX_ADV, 2'b00);
    chk({15'h0, rv[13]}, 16'h0001);
    chk({15'h0, tx_word[13]}, 16'h0001);
    local_fault <= 1'b0;
    mode <= 3'd2;
    wr(`ANPM_IDX_CTRL, 16'h0000, 2'b00);
    rd(`ANPM_IDX_CTRL, 2'b00);
    chk({15'h0, tx_flp_en}, 16'h0000);
    wr(`ANPM_IDX_CTRL, 16'h1000, 2'b00);
    poll(`ANPM_IDX_STAT, 5, 1'b0);
    poll(`ANPM_IDX_STAT, 5, 1'b1);
    rd(`ANPM_IDX_EXP, 2'b00);
    chk({15'h0, rv[0]}, 16'h0000);
    rd(`ANPM_IDX_LPA, 2'b00);
    chk(rv[15:0], 16'h0020);
    chk({13'h0, en_100tx, en_10t, full_duplex}, 16'h0002);
    mode <= 3'd3;
    wr(`ANPM_IDX_CTRL, 16'h1200, 2'b00);
    poll(`ANPM_IDX_STAT, 5, 1'b0);
    poll(`ANPM_IDX_STAT, 5, 1'b1);
    rd(`ANPM_IDX_LPA, 2'b00);
    chk(rv[15:0], 16'h0080);
    chk({13'h0, en_100tx, en_10t, full_duplex}, 16'h0004);
    rd(`ANPM_IDX_CSR, 2'b00);
    chk({14'h0, rv[15:14]}, 16'h0002);
    mode <= 3'd0;
    poll(`ANPM_IDX_STAT, 5, 1'b0);
    rd(`ANPM_IDX_CSR, 2'b00);
    chk({15'h0, rv[3]}, 16'h0001);
    mode <= 3'd4;
    poll(`ANPM_IDX_EXP, 4, 1'b1);
    chk({14'h0, en_100tx, en_10t}, 16'h0000);
    wr(`ANPM_IDX_CTRL, 16'h9000, 2'b00);
    rd(`ANPM_IDX_EXP, 2'b00);
    chk({15'h0, rv[4]}, 16'h0000);
    rd(`ANPM_IDX_CSR, 2'b00);
    chk({14'h0, rv[4], rv[13]}, 16'h0000);
    test_done;
  end
endmodule // autoneg_parallel_detect_monitor_bench
